// ===== pkg/half_word_multiply_pkg.sv
// half-word multiply unit constants: instruction fields, operation codes, widths
// assumes a 32-bit instruction word and 32-bit general registers
package half_word_multiply_pkg;
	// ********************
	// instruction fields
	// ********************
	localparam int COND_REG_MSB    = 31;
	localparam int COND_REG_LSB    = 29;
	localparam int COND_ZERO_BIT   = 28;
	localparam int DST_MSB         = 27;
	localparam int DST_LSB         = 23;
	localparam int SRC2_MSB        = 22;
	localparam int SRC2_LSB        = 18;
	localparam int SRC1_MSB        = 17;
	localparam int SRC1_LSB        = 13;
	localparam int CROSS_BIT       = 12;
	localparam int OP_MSB          = 11;
	localparam int OP_LSB          = 7;
	localparam int PAD_MSB         = 6;
	localparam int PAD_LSB         = 2;
	localparam int SIDE_BIT        = 1;
	localparam int CHAIN_BIT       = 0;
	localparam logic [4:0] PAD_ZERO = 5'h00;
	// ********************
	// operation codes
	// ********************
	localparam logic [4:0] OP_UHIGH_BY_SHIGH = 5'h05;
	localparam logic [4:0] OP_SLOW_BY_SHIGH  = 5'h11;
	localparam logic [4:0] OP_ULOW_BY_UHIGH  = 5'h17;
	localparam logic [4:0] OP_SLOW_BY_UHIGH  = 5'h13;
	localparam logic [4:0] OP_ULOW_BY_SHIGH  = 5'h15;
	localparam logic [4:0] OP_SLOW_BY_ULOW   = 5'h1B;
	localparam logic [4:0] OP_SLOW_BY_ULOW_K = 5'h1E;
	localparam logic [4:0] OP_ULOW_BY_ULOW   = 5'h1F;
	localparam logic [4:0] OP_ULOW_BY_SLOW   = 5'h1D;
	// ********************
	// widths and reset values
	// ********************
	localparam int REG_ADDR_W = 5;
	localparam int DATA_W     = 32;
	localparam int HALF_W     = 16;
	localparam logic [31:0] PRODUCT_RESET = 32'h0000_0000;
endpackage

// ===== core/half_mult_core.sv
// signed/unsigned 16x16 multiplier core, combinational
// assumes operands already selected; the caller registers the product
`timescale 1ns/100ps
module half_mult_core (
	input  wire logic [15:0] i_a,
	input  wire logic        i_a_signed,
	input  wire logic [15:0] i_b,
	input  wire logic        i_b_signed,
	output logic      [31:0] o_product
);
	logic signed [16:0] a_ext;
	logic signed [16:0] b_ext;
	logic signed [33:0] full;
	// sign or zero extension keeps every mix exact
	assign a_ext     = {i_a_signed & i_a[15], i_a};
	assign b_ext     = {i_b_signed & i_b[15], i_b};
	assign full      = a_ext * b_ext;
	assign o_product = full[31:0];
endmodule

// ===== core/half_word_multiply_unit.sv
// half-word multiply unit: decode, operand read in stage one, write in stage two
// assumes register files answer reads combinationally and condition truth is supplied
`timescale 1ns/100ps
// Function
// - mul_uhigh_by_shigh multiplies unsigned upper half of src1 by signed upper half of src2.
// - mul_slow_by_shigh multiplies signed low half of src1 by signed upper half of src2.
// - mul_ulow_by_uhigh multiplies unsigned low half of src1 by unsigned upper half of src2.
// - mul_ulow_by_shigh multiplies unsigned low half of src1 by signed upper half of src2.
// - mul_slow_by_ulow multiplies signed low src1 (code 11011) or a signed 5-bit src1-field constant (code 11110) by unsigned low src2.
// - mul_ulow_by_slow multiplies unsigned low half of src1 by signed low half of src2.
// - the destination is written only when the condition is true, otherwise nothing changes.
// - sources are read in stage one and the product written in stage two, one delay slot.
// - only mult_unit_a or mult_unit_b take these operations, each with two sources and a dst.
// - mul_ulow_by_slow is recognised by code 11101 with bits 6 to 2 zero.
// - mul_ulow_by_uhigh is recognised by code 10111 with bits 6 to 2 zero.
module half_word_multiply_unit (
	input  wire logic                                       i_ref_clk,
	input  wire logic                                       i_sys_rst,
	input  wire logic                                       i_issue,
	input  wire logic [31:0]                                i_instr,
	input  wire logic                                       i_cond_true,
	input  wire logic [half_word_multiply_pkg::DATA_W-1:0]  i_src1_data,
	input  wire logic [half_word_multiply_pkg::DATA_W-1:0]  i_src2_data,
	input  wire logic [half_word_multiply_pkg::DATA_W-1:0]  i_src2_cross_data,
	output logic                                            o_accept,
	output logic [2:0]                                      o_cond_reg_select,
	output logic                                            o_cond_zero_sense,
	output logic [half_word_multiply_pkg::REG_ADDR_W-1:0]   o_src1_addr,
	output logic [half_word_multiply_pkg::REG_ADDR_W-1:0]   o_src2_addr,
	output logic                                            o_cross_path_select,
	output logic                                            o_unit_a_busy,
	output logic                                            o_unit_b_busy,
	output logic                                            o_parallel_chain,
	output logic                                            o_wr_en,
	output logic                                            o_wr_side_b,
	output logic [half_word_multiply_pkg::REG_ADDR_W-1:0]   o_wr_addr,
	output logic [half_word_multiply_pkg::DATA_W-1:0]       o_wr_data
);
	import half_word_multiply_pkg::*;

	// ********************
	// decode
	// ********************
	logic [4:0]            op_code;
	logic [4:0]            pad_bits;
	logic [REG_ADDR_W-1:0] dst_addr;
	logic                  known_op;
	logic                  a_high;
	logic                  a_signed;
	logic                  b_high;
	logic                  b_signed;
	logic                  a_is_const;

	assign op_code             = i_instr[OP_MSB:OP_LSB];
	assign pad_bits            = i_instr[PAD_MSB:PAD_LSB];
	assign dst_addr            = i_instr[DST_MSB:DST_LSB];
	assign o_src1_addr         = i_instr[SRC1_MSB:SRC1_LSB];
	assign o_src2_addr         = i_instr[SRC2_MSB:SRC2_LSB];
	assign o_cond_reg_select   = i_instr[COND_REG_MSB:COND_REG_LSB];
	assign o_cond_zero_sense   = i_instr[COND_ZERO_BIT];
	assign o_cross_path_select = i_instr[CROSS_BIT];

	always_comb begin
		known_op   = 1'b1;
		a_high     = 1'b0;
		a_signed   = 1'b0;
		b_high     = 1'b0;
		b_signed   = 1'b0;
		a_is_const = 1'b0;
		case (op_code)
			OP_UHIGH_BY_SHIGH: begin
				a_high   = 1'b1;
				b_high   = 1'b1;
				b_signed = 1'b1;
			end
			OP_SLOW_BY_SHIGH: begin
				a_signed = 1'b1;
				b_high   = 1'b1;
				b_signed = 1'b1;
			end
			OP_ULOW_BY_UHIGH: begin
				b_high = 1'b1;
			end
			OP_SLOW_BY_UHIGH: begin
				a_signed = 1'b1;
				b_high   = 1'b1;
			end
			OP_ULOW_BY_SHIGH: begin
				b_high   = 1'b1;
				b_signed = 1'b1;
			end
			OP_SLOW_BY_ULOW: begin
				a_signed = 1'b1;
			end
			OP_SLOW_BY_ULOW_K: begin
				a_signed   = 1'b1;
				a_is_const = 1'b1;
			end
			OP_ULOW_BY_ULOW: begin
				known_op = 1'b1;
			end
			OP_ULOW_BY_SLOW: begin
				b_signed = 1'b1;
			end
			default: begin
				known_op = 1'b0;
			end
		endcase
	end

	// only a clean pad field is a multiply on this unit
	assign o_accept = i_issue & known_op & (pad_bits == PAD_ZERO);

	// ********************
	// stage one: operand read and multiply
	// ********************
	logic [DATA_W-1:0] src2_sel;
	logic [15:0]       a_half;
	logic [15:0]       b_half;
	logic [31:0]       product;

	// cross path takes src2 from the opposite file
	assign src2_sel = o_cross_path_select ? i_src2_cross_data : i_src2_data;
	// 5-bit signed constant sits in the src1 field
	assign a_half   = a_is_const ? {{11{o_src1_addr[4]}}, o_src1_addr}
	                : (a_high ? i_src1_data[31:16] : i_src1_data[15:0]);
	assign b_half   = b_high ? src2_sel[31:16] : src2_sel[15:0];

	half_mult_core u_core (
		.i_a        (a_half),
		.i_a_signed (a_signed),
		.i_b        (b_half),
		.i_b_signed (b_signed),
		.o_product  (product)
	);

	// side bit steers to unit b, chain bit flags parallel issue
	assign o_unit_a_busy    = o_accept & ~i_instr[SIDE_BIT];
	assign o_unit_b_busy    = o_accept & i_instr[SIDE_BIT];
	assign o_parallel_chain = i_issue & i_instr[CHAIN_BIT];

	// ********************
	// stage two: write back
	// ********************
	// false condition behaves as a no-operation, no write strobe
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_wr_en <= 1'b0;
		end else begin
			o_wr_en <= o_accept & i_cond_true;
		end
	end

	// data held when no write, so a skipped op leaves the old value visible
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_wr_data   <= PRODUCT_RESET;
			o_wr_addr   <= '0;
			o_wr_side_b <= 1'b0;
		end else if (o_accept & i_cond_true) begin
			o_wr_data   <= product;
			o_wr_addr   <= dst_addr;
			o_wr_side_b <= i_instr[SIDE_BIT];
		end
	end

	// ********************
	// checks
	// ********************
	write_follows_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(o_accept && i_cond_true) |=> o_wr_en)
		else $error("write did not follow accepted op");
	false_cond_nop_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(!o_accept || !i_cond_true) |=> (!o_wr_en && $stable(o_wr_data)))
		else $error("write on false condition");
	product_value_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(o_accept && i_cond_true) |=> (o_wr_data == $past(product)))
		else $error("written product wrong");
	uhigh_shigh_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(o_accept && op_code == OP_UHIGH_BY_SHIGH) |->
		(product == {16'h0000, i_src1_data[31:16]} * {{16{src2_sel[31]}}, src2_sel[31:16]}))
		else $error("uhigh by shigh wrong");
	slow_shigh_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(o_accept && op_code == OP_SLOW_BY_SHIGH) |->
		(product == {{16{i_src1_data[15]}}, i_src1_data[15:0]}
		* {{16{src2_sel[31]}}, src2_sel[31:16]}))
		else $error("slow by shigh wrong");
	ulow_uhigh_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(o_accept && op_code == OP_ULOW_BY_UHIGH) |->
		(product == 32'(i_src1_data[15:0]) * 32'(src2_sel[31:16])))
		else $error("ulow by uhigh wrong");
	ulow_shigh_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(o_accept && op_code == OP_ULOW_BY_SHIGH) |->
		(product == {16'h0000, i_src1_data[15:0]} * {{16{src2_sel[31]}}, src2_sel[31:16]}))
		else $error("ulow by shigh wrong");
	ulow_slow_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(o_accept && op_code == OP_ULOW_BY_SLOW) |->
		(product == {16'h0000, i_src1_data[15:0]} * {{16{src2_sel[15]}}, src2_sel[15:0]}))
		else $error("ulow by slow wrong");
	// 32-bit extended operands keep the reference exact, no cast width ambiguity
	slow_ulow_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(o_accept && op_code == OP_SLOW_BY_ULOW) |->
		(product == {{16{i_src1_data[15]}}, i_src1_data[15:0]} * {16'h0000, src2_sel[15:0]}))
		else $error("slow by ulow wrong");
	const_ulow_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(o_accept && op_code == OP_SLOW_BY_ULOW_K) |->
		(product == {{27{o_src1_addr[4]}}, o_src1_addr} * {16'h0000, src2_sel[15:0]}))
		else $error("constant by ulow wrong");
	pad_reject_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(pad_bits != PAD_ZERO) |-> !o_accept)
		else $error("accepted with nonzero pad");
	one_unit_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		!(o_unit_a_busy && o_unit_b_busy) && (o_accept == (o_unit_a_busy || o_unit_b_busy)))
		else $error("unit busy mismatch");
	ulow_uhigh_dec_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(i_issue && i_instr[OP_MSB:OP_LSB] == 5'h17 && i_instr[PAD_MSB:PAD_LSB] == 5'h00) |-> o_accept)
		else $error("ulow by uhigh not accepted");
	cross_path_a : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_instr[CROSS_BIT] |-> (src2_sel == i_src2_cross_data))
		else $error("cross path not taken");
endmodule

// ===== testbench/reg_file_model.sv
// two 32-entry register files, read combinationally, written on wr_en
// assumes the bench preloads entries through hierarchical writes
`timescale 1ns/100ps
module reg_file_model (
	input  wire logic        i_ref_clk,
	input  wire logic        i_side_b,
	input  wire logic [4:0]  i_src1_addr,
	input  wire logic [4:0]  i_src2_addr,
	input  wire logic        i_wr_en,
	input  wire logic        i_wr_side_b,
	input  wire logic [4:0]  i_wr_addr,
	input  wire logic [31:0] i_wr_data,
	output logic      [31:0] o_src1_data,
	output logic      [31:0] o_src2_data,
	output logic      [31:0] o_src2_cross_data
);
	logic [31:0] file_a [32];
	logic [31:0] file_b [32];
	// own file for both sources, opposite file on the cross path
	assign o_src1_data       = i_side_b ? file_b[i_src1_addr] : file_a[i_src1_addr];
	assign o_src2_data       = i_side_b ? file_b[i_src2_addr] : file_a[i_src2_addr];
	assign o_src2_cross_data = i_side_b ? file_a[i_src2_addr] : file_b[i_src2_addr];
	always @(posedge i_ref_clk) begin
		if (i_wr_en && i_wr_side_b)
			file_b[i_wr_addr] <= i_wr_data;
		else if (i_wr_en)
			file_a[i_wr_addr] <= i_wr_data;
	end
endmodule

// ===== testbench/tb.sv
// bench for the half-word multiply unit with a register file model
// assumes inputs change 1 ns after the rising edge
`timescale 1ns/100ps
module tb;
	import half_word_multiply_pkg::*;
	logic i_ref_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_issue = 1'b0;
	logic [31:0] i_instr = 32'h0000_0000;
	logic i_cond_true = 1'b0;
	logic [31:0] s1, s2, s2x, wd;
	logic [4:0] a1, a2, wa;
	logic acc, crs, ba, bb, chn, we, wsb, cz;
	logic [2:0] cr;
	int n_mismatch = 0;
	int n_tests = 0;
	always #20 i_ref_clk = ~i_ref_clk;
	half_word_multiply_unit DUT (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
		.i_issue(i_issue), .i_instr(i_instr), .i_cond_true(i_cond_true), .i_src1_data(s1),
		.i_src2_data(s2), .i_src2_cross_data(s2x), .o_accept(acc), .o_cond_reg_select(cr),
		.o_cond_zero_sense(cz), .o_src1_addr(a1), .o_src2_addr(a2), .o_cross_path_select(crs),
		.o_unit_a_busy(ba), .o_unit_b_busy(bb), .o_parallel_chain(chn), .o_wr_en(we),
		.o_wr_side_b(wsb), .o_wr_addr(wa), .o_wr_data(wd));
	reg_file_model rf (.i_ref_clk(i_ref_clk), .i_side_b(i_instr[SIDE_BIT]),
		.i_src1_addr(a1), .i_src2_addr(a2), .i_wr_en(we), .i_wr_side_b(wsb),
		.i_wr_addr(wa), .i_wr_data(wd), .o_src1_data(s1), .o_src2_data(s2),
		.o_src2_cross_data(s2x));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [31:0] prod(input logic [15:0] a, input logic sa,
		input logic [15:0] b, input logic sb);
		// extend first so the truncated product stays exact
		return {{16{sa & a[15]}}, a} * {{16{sb & b[15]}}, b};
	endfunction
	function automatic logic [31:0] mk(input logic [4:0] op, input logic [4:0] d,
		input logic [4:0] r2, input logic [4:0] r1, input logic x, input logic sd);
		return {3'h5, 1'h1, d, r2, r1, x, op, 5'h00, sd, sd};
	endfunction
	// one issue, then the write one cycle later
	task automatic run(input logic [31:0] ins, input logic cnd, input logic ac,
		input logic wr, input logic [31:0] ed);
		@(posedge i_ref_clk);
		#1 i_issue = 1'b1;
		i_instr = ins;
		i_cond_true = cnd;
		#1 chk("accept", 32'(ac), 32'(acc));
		chk("busy", 32'(ac), 32'(ins[SIDE_BIT] ? bb : ba));
		@(posedge i_ref_clk);
		#1 i_issue = 1'b0;
		chk("wr_en", 32'(wr), 32'(we));
		chk("wr_data", ed, wd);
		if (wr)
			chk("wr_addr", 32'(ins[DST_MSB:DST_LSB]), 32'(wa));
	endtask
	task automatic all_ops();
		logic [4:0] ops [8] = '{OP_UHIGH_BY_SHIGH, OP_SLOW_BY_SHIGH, OP_ULOW_BY_UHIGH,
			OP_SLOW_BY_UHIGH, OP_ULOW_BY_SHIGH, OP_SLOW_BY_ULOW, OP_ULOW_BY_ULOW, OP_ULOW_BY_SLOW};
		logic [7:0] h1 = 8'h01, g1 = 8'h2A, h2 = 8'h1F, g2 = 8'h93;
		logic [31:0] x = 32'hFFA1_8123, y = 32'h8002_FA81;
		for (int i = 0; i < 8; i++)
			run(mk(ops[i], 5'(10 + i), 5'h04, 5'h03, 1'b0, 1'b0), 1'b1, 1'b1, 1'b1,
				prod(h1[i] ? x[31:16] : x[15:0], g1[i], h2[i] ? y[31:16] : y[15:0], g2[i]));
		run(mk(OP_SLOW_BY_ULOW_K, 5'h12, 5'h04, 5'h1A, 1'b0, 1'b0), 1'b1, 1'b1, 1'b1,
			prod(16'hFFFA, 1'b1, y[15:0], 1'b0));
	endtask
	task automatic false_cond();
		logic [31:0] held;
		held = wd;
		run(mk(OP_ULOW_BY_ULOW, 5'h13, 5'h04, 5'h03, 1'b0, 1'b0), 1'b0, 1'b1, 1'b0, held);
	endtask
	task automatic bad_pad();
		logic [31:0] held;
		held = wd;
		run(mk(OP_ULOW_BY_SLOW, 5'h14, 5'h04, 5'h03, 1'b0, 1'b0) | 32'h4, 1'b1, 1'b0, 1'b0,
			held);
	endtask
	task automatic cross_b();
		rf.file_b[5] = 32'h0003_0007;
		run(mk(OP_ULOW_BY_ULOW, 5'h15, 5'h04, 5'h05, 1'b1, 1'b1), 1'b1, 1'b1, 1'b1,
			32'h0007 * 32'hFA81);
		chk("side_b", 32'h1, 32'(wsb));
		@(posedge i_ref_clk);
		#1 i_issue = 1'b1;
		#1 chk("fields", 32'h0000_00BC, {cr, cz, crs, chn, 1'b0, ba});
		@(posedge i_ref_clk);
		#1 i_issue = 1'b0;
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		rf.file_a[3] = 32'hFFA1_8123;
		rf.file_a[4] = 32'h8002_FA81;
		repeat (8) @(posedge i_ref_clk);
		#1 i_sys_rst = 1'b0;
		all_ops();
		false_cond();
		bad_pad();
		cross_b();
		report_and_stop();
	end
	initial begin
		#80000;
		n_mismatch++;
		report_and_stop();
	end
endmodule
